// [hcd_pkg.sv]
// constants for the hall commutation decoder: sensor codes, step tables, pwm timing
// assumes a single 200 MHz clock and sensor inputs already synchronous to it
// Notes on behaviour
// - the 60 degree code order is the 300 degree order reversed; one decode
// - the 120 and 240 degree code orders are reverses; one decode serves both
// - select high, direction high drives a 60 degree motor forward, 300 in reverse
// - select high picks 60/300 decoding, select low picks 120/240 decoding
// - 60 degree mode with b tied to c gives four states on b/c drives
// - four-step forward: a,b 10,11,01,00 give b/c top/bottom 1101,0100,1000,1110
// - four-step reverse: a,b 10,11,01,00 give b/c top/bottom 1000,1110,1101,0100
// - brush code 100: direction 1 top a, bottom c; direction 0 top c, bottom a
// - conduction is gated by a pwm running at about 25 kHz
// - overcurrent ends conduction within the current pwm cycle
// - each valid code enables one top and one bottom drive of different phases
// - at most one conduction pulse per pwm oscillator cycle
package hcd_pkg;
    // timing
    localparam int CLK_FREQ_KHZ = 200000;
    localparam int PWM_FREQ_KHZ = 25;
    localparam int PWM_PERIOD_CYC = CLK_FREQ_KHZ / PWM_FREQ_KHZ;
    localparam int PWM_CNT_W = 13;

    // step indices
    localparam logic [2:0] STEP_0 = 3'h0;
    localparam logic [2:0] STEP_1 = 3'h1;
    localparam logic [2:0] STEP_2 = 3'h2;
    localparam logic [2:0] STEP_3 = 3'h3;
    localparam logic [2:0] STEP_4 = 3'h4;
    localparam logic [2:0] STEP_5 = 3'h5;
    localparam logic [2:0] STEP_NONE = 3'h6;

    // sensor codes {a,b,c} for each step, 60/300 phasing
    localparam logic [2:0] C60_S0 = 3'h4;
    localparam logic [2:0] C60_S1 = 3'h6;
    localparam logic [2:0] C60_S2 = 3'h7;
    localparam logic [2:0] C60_S3 = 3'h3;
    localparam logic [2:0] C60_S4 = 3'h1;
    localparam logic [2:0] C60_S5 = 3'h0;
    // sensor codes for each step, 120/240 phasing
    localparam logic [2:0] C120_S0 = 3'h5;
    localparam logic [2:0] C120_S1 = 3'h4;
    localparam logic [2:0] C120_S2 = 3'h6;
    localparam logic [2:0] C120_S3 = 3'h2;
    localparam logic [2:0] C120_S4 = 3'h3;
    localparam logic [2:0] C120_S5 = 3'h1;

    // phase one-hot, bit 0 is phase a
    localparam logic [2:0] PH_A = 3'h1;
    localparam logic [2:0] PH_B = 3'h2;
    localparam logic [2:0] PH_C = 3'h4;
    localparam logic [2:0] PH_NONE = 3'h0;

    // forward phase per step packed {s5..s0}; reverse swaps top and bottom
    localparam logic [17:0] TOP_FWD_TBL = {PH_A, PH_C, PH_C, PH_B, PH_B, PH_A};
    localparam logic [17:0] BOT_FWD_TBL = {PH_B, PH_B, PH_A, PH_A, PH_C, PH_C};
    localparam logic [4:0] TBL_STRIDE = 5'h3;

    // pin levels: top drives are open collector, low means conducting
    localparam logic [2:0] UPPER_ALL_OFF = 3'h7;
    localparam logic [2:0] LOWER_ALL_OFF = 3'h0;
endpackage : hcd_pkg

// [hcd_pwm_gate.sv]
// pwm oscillator with a dual latch that allows one conduction pulse per period
// assumes duty_level and over_current synchronous to clk
`timescale 1ns/100ps
module hcd_pwm_gate #(
    parameter int PERIOD_CYC = hcd_pkg::PWM_PERIOD_CYC,
    parameter int CNT_W = hcd_pkg::PWM_CNT_W
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic [CNT_W-1:0] duty_level,
    input wire logic over_current,
    output logic pwm_on
);
    localparam logic [CNT_W-1:0] CNT_ZERO = '0;
    localparam logic [CNT_W-1:0] CNT_LAST = CNT_W'(PERIOD_CYC - 1);
    localparam logic [CNT_W-1:0] CNT_ONE = CNT_W'(1);

    logic [CNT_W-1:0] cnt_ff;
    logic pwm_on_ff;
    logic pulse_ended_ff;

    // sawtooth counter wraps every period
    wire cnt_wrap = (cnt_ff == CNT_LAST);
    wire [CNT_W-1:0] nxt_cnt = cnt_wrap ? CNT_ZERO : cnt_ff + CNT_ONE;
    wire cycle_start = (cnt_ff == CNT_ZERO);
    // reset terms outrank the set, so a pulse cut short is never re-armed mid-period
    wire pulse_stop = over_current || (cnt_ff >= duty_level);
    wire nxt_on = pulse_stop ? 1'b0 : (cycle_start ? 1'b1 : pwm_on_ff);

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            cnt_ff <= CNT_ZERO;
            pwm_on_ff <= 1'b0;
        end else begin
            cnt_ff <= nxt_cnt;
            pwm_on_ff <= nxt_on;
        end
    end

    // checking aid only: marks that this period's pulse is already over
    always_ff @(posedge clk) begin
        if (!rst_n || cycle_start) begin
            pulse_ended_ff <= 1'b0;
        end else if (pwm_on_ff && !nxt_on) begin
            pulse_ended_ff <= 1'b1;
        end
    end

    assign pwm_on = pwm_on_ff;

    a_pulse_at_start: assert property (@(posedge clk) disable iff (!rst_n)
        $rose(pwm_on_ff) |-> $past(cnt_ff) == CNT_ZERO)
        else $error("pwm pulse began away from the period start");
    a_period_wraps: assert property (@(posedge clk) disable iff (!rst_n)
        cnt_ff == CNT_LAST |=> cnt_ff == CNT_ZERO)
        else $error("pwm counter did not wrap at the period end");
    a_single_pulse: assert property (@(posedge clk) disable iff (!rst_n)
        pulse_ended_ff |-> !pwm_on_ff)
        else $error("second conduction pulse inside one period");
    a_overcurrent_cut: assert property (@(posedge clk) disable iff (!rst_n)
        over_current |=> !pwm_on_ff)
        else $error("pwm pulse survived an overcurrent");
endmodule : hcd_pwm_gate

// [hcd_top.sv]
// hall commutation decoder: sensor code plus phasing and direction to six drives
// assumes sensor, select and direction inputs synchronous to clk; drives go
// to an external bridge, top pins low-active (open collector), bottom pins high-active
`timescale 1ns/100ps
module hcd_top #(
    parameter int PWM_PERIOD_CYC = hcd_pkg::PWM_PERIOD_CYC,
    parameter int CNT_W = hcd_pkg::PWM_CNT_W
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic hall_in_a,
    input wire logic hall_in_b,
    input wire logic hall_in_c,
    input wire logic phase_sel,
    input wire logic direction_sel,
    input wire logic [CNT_W-1:0] duty_level,
    input wire logic over_current,
    output logic upper_drive_a,
    output logic upper_drive_b,
    output logic upper_drive_c,
    output logic lower_drive_a,
    output logic lower_drive_b,
    output logic lower_drive_c,
    output logic step_valid,
    output logic pwm_active
);
    logic [2:0] upper_ff;
    logic [2:0] lower_ff;
    logic step_valid_ff;
    logic pwm_active_ff;
    logic pwm_on;

    // pwm oscillator and dual latch
    hcd_pwm_gate #(
        .PERIOD_CYC(PWM_PERIOD_CYC),
        .CNT_W(CNT_W)
    ) u_pwm (
        .clk(clk),
        .rst_n(rst_n),
        .duty_level(duty_level),
        .over_current(over_current),
        .pwm_on(pwm_on)
    );

    // sensor code, bit 2 is sensor a
    wire [2:0] hall_code = {hall_in_a, hall_in_b, hall_in_c};

    // 60/300 decode; 300 runs the same steps backwards, so no table of its own
    // four-step use with b tied to c lands on steps 0, 2, 3, 5 only
    wire [2:0] step60 =
        (hall_code == hcd_pkg::C60_S0) ? hcd_pkg::STEP_0 :
        (hall_code == hcd_pkg::C60_S1) ? hcd_pkg::STEP_1 :
        (hall_code == hcd_pkg::C60_S2) ? hcd_pkg::STEP_2 :
        (hall_code == hcd_pkg::C60_S3) ? hcd_pkg::STEP_3 :
        (hall_code == hcd_pkg::C60_S4) ? hcd_pkg::STEP_4 :
        (hall_code == hcd_pkg::C60_S5) ? hcd_pkg::STEP_5 : hcd_pkg::STEP_NONE;

    // 120/240 decode; 240 is the same order reversed
    wire [2:0] step120 =
        (hall_code == hcd_pkg::C120_S0) ? hcd_pkg::STEP_0 :
        (hall_code == hcd_pkg::C120_S1) ? hcd_pkg::STEP_1 :
        (hall_code == hcd_pkg::C120_S2) ? hcd_pkg::STEP_2 :
        (hall_code == hcd_pkg::C120_S3) ? hcd_pkg::STEP_3 :
        (hall_code == hcd_pkg::C120_S4) ? hcd_pkg::STEP_4 :
        (hall_code == hcd_pkg::C120_S5) ? hcd_pkg::STEP_5 : hcd_pkg::STEP_NONE;

    // phasing select: open (high) for 60/300, grounded for 120/240
    wire [2:0] step_idx = phase_sel ? step60 : step120;
    // illegal codes (a broken sensor line) switch everything off rather than guess
    wire step_ok = (step_idx != hcd_pkg::STEP_NONE);
    wire [2:0] step_base = step_ok ? step_idx : hcd_pkg::STEP_0;
    wire [4:0] tbl_base = 5'({2'h0, step_base} * hcd_pkg::TBL_STRIDE);

    // table lookup; each step names one top and one bottom phase, never the same
    wire [2:0] top_fwd = hcd_pkg::TOP_FWD_TBL[tbl_base +: 3];
    wire [2:0] bot_fwd = hcd_pkg::BOT_FWD_TBL[tbl_base +: 3];

    // direction swaps top and bottom, which is what runs the motor backwards
    wire [2:0] top_on = direction_sel ? top_fwd : bot_fwd;
    wire [2:0] bot_on = direction_sel ? bot_fwd : top_fwd;

    // pwm gates only the bottom switches; overcurrent is also taken directly
    // so the cut reaches the pins one edge earlier than through the latch
    wire conduct = pwm_on && !over_current;
    wire [2:0] nxt_upper = step_ok ? ~top_on : hcd_pkg::UPPER_ALL_OFF;
    wire [2:0] nxt_lower = (step_ok && conduct) ? bot_on : hcd_pkg::LOWER_ALL_OFF;

    // output registers
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            upper_ff <= hcd_pkg::UPPER_ALL_OFF;
            lower_ff <= hcd_pkg::LOWER_ALL_OFF;
            step_valid_ff <= 1'b0;
            pwm_active_ff <= 1'b0;
        end else begin
            upper_ff <= nxt_upper;
            lower_ff <= nxt_lower;
            step_valid_ff <= step_ok;
            pwm_active_ff <= conduct;
        end
    end

    // pins straight from the registers
    assign upper_drive_a = upper_ff[0];
    assign upper_drive_b = upper_ff[1];
    assign upper_drive_c = upper_ff[2];
    assign lower_drive_a = lower_ff[0];
    assign lower_drive_b = lower_ff[1];
    assign lower_drive_c = lower_ff[2];
    assign step_valid = step_valid_ff;
    assign pwm_active = pwm_active_ff;

    a_one_top_bottom: assert property (@(posedge clk) disable iff (!rst_n)
        step_valid_ff |-> $onehot(~upper_ff) && ((~upper_ff & lower_ff) == 3'h0)
            && ($countones(lower_ff) <= 1))
        else $error("drive pair not one top and one bottom of different phases");
    a_off_when_bad: assert property (@(posedge clk) disable iff (!rst_n)
        (!phase_sel && hall_code == 3'h7) || (phase_sel && hall_code == 3'h2)
        |=> upper_ff == hcd_pkg::UPPER_ALL_OFF && lower_ff == hcd_pkg::LOWER_ALL_OFF)
        else $error("illegal code for selected phasing still drives");
    a_sixty_fwd: assert property (@(posedge clk) disable iff (!rst_n)
        phase_sel && direction_sel && hall_code == 3'h6
        |=> !upper_drive_b && upper_drive_a && upper_drive_c
            && lower_drive_c == $past(conduct))
        else $error("60 degree forward step wrong");
    a_sixty_reverse: assert property (@(posedge clk) disable iff (!rst_n)
        phase_sel && !direction_sel && hall_code == 3'h7
        |=> !upper_drive_a && lower_drive_b == $past(conduct) && !lower_drive_a)
        else $error("300 degree order not served by reversed decode");
    a_onetwenty_fwd: assert property (@(posedge clk) disable iff (!rst_n)
        !phase_sel && direction_sel && hall_code == 3'h6
        |=> !upper_drive_b && lower_drive_a == $past(conduct) && step_valid)
        else $error("120 degree step wrong");
    // with b tied to c only four codes reach the decoder; one b/c switch at a time
    a_four_valid: assert property (@(posedge clk) disable iff (!rst_n)
        phase_sel && (hall_in_b == hall_in_c)
        |=> step_valid && ($countones({!upper_drive_b, !upper_drive_c, lower_drive_b,
            lower_drive_c}) <= 1))
        else $error("tied b/c code not decoded in 60 degree mode");
    a_four_fwd: assert property (@(posedge clk) disable iff (!rst_n)
        phase_sel && direction_sel && hall_code == 3'h4
        |=> upper_drive_b && upper_drive_c && !lower_drive_b
            && lower_drive_c == $past(conduct))
        else $error("four-step forward 10 pattern wrong");
    a_four_rev: assert property (@(posedge clk) disable iff (!rst_n)
        phase_sel && !direction_sel && hall_code == 3'h0
        |=> !upper_drive_b && upper_drive_c && !lower_drive_b && !lower_drive_c)
        else $error("four-step reverse 00 pattern wrong");
    a_brush_rev: assert property (@(posedge clk) disable iff (!rst_n)
        phase_sel && !direction_sel && hall_code == 3'h4
        |=> !upper_drive_c && upper_drive_a && lower_drive_a == $past(conduct)
            && !lower_drive_c)
        else $error("brush reverse drive pair wrong");
    a_cut_in_cycle: assert property (@(posedge clk) disable iff (!rst_n)
        over_current |=> lower_ff == hcd_pkg::LOWER_ALL_OFF ##1
            (lower_ff == hcd_pkg::LOWER_ALL_OFF || $past(conduct)))
        else $error("bottom drive not cut on overcurrent");

    // remaining four-step rows, so every line of both tables is guarded
    a_four_fwd_11: assert property (@(posedge clk) disable iff (!rst_n)
        phase_sel && direction_sel && hall_code == 3'h7
        |=> !upper_drive_b && upper_drive_c && !lower_drive_b && !lower_drive_c)
        else $error("four-step forward 11 pattern wrong");
    a_four_fwd_01: assert property (@(posedge clk) disable iff (!rst_n)
        phase_sel && direction_sel && hall_code == 3'h3
        |=> upper_drive_b && !upper_drive_c && !lower_drive_b && !lower_drive_c)
        else $error("four-step forward 01 pattern wrong");
    a_four_fwd_00: assert property (@(posedge clk) disable iff (!rst_n)
        phase_sel && direction_sel && hall_code == 3'h0
        |=> upper_drive_b && upper_drive_c && lower_drive_b == $past(conduct) && !lower_drive_c)
        else $error("four-step forward 00 pattern wrong");
    a_four_rev_10: assert property (@(posedge clk) disable iff (!rst_n)
        phase_sel && !direction_sel && hall_code == 3'h4
        |=> upper_drive_b && !upper_drive_c && !lower_drive_b && !lower_drive_c)
        else $error("four-step reverse 10 pattern wrong");
    a_four_rev_11: assert property (@(posedge clk) disable iff (!rst_n)
        phase_sel && !direction_sel && hall_code == 3'h7
        |=> upper_drive_b && upper_drive_c && lower_drive_b == $past(conduct) && !lower_drive_c)
        else $error("four-step reverse 11 pattern wrong");
    a_four_rev_01: assert property (@(posedge clk) disable iff (!rst_n)
        phase_sel && !direction_sel && hall_code == 3'h3
        |=> upper_drive_b && upper_drive_c && !lower_drive_b && lower_drive_c == $past(conduct))
        else $error("four-step reverse 01 pattern wrong");

    // brush code forward: top of phase a with bottom of phase c
    a_brush_fwd: assert property (@(posedge clk) disable iff (!rst_n)
        phase_sel && direction_sel && hall_code == 3'h4
        |=> !upper_drive_a && upper_drive_b && upper_drive_c
            && lower_drive_c == $past(conduct) && !lower_drive_a && !lower_drive_b)
        else $error("brush forward drive pair wrong");

    // further steps: 60/300 decode forward only, 120/240 decode forward and reversed
    a_sixty_step4: assert property (@(posedge clk) disable iff (!rst_n)
        phase_sel && direction_sel && hall_code == 3'h1
        |=> !upper_drive_c && upper_drive_a && upper_drive_b
            && lower_drive_b == $past(conduct) && !lower_drive_a && !lower_drive_c)
        else $error("60 degree step 4 wrong");
    a_onetwenty_s0: assert property (@(posedge clk) disable iff (!rst_n)
        !phase_sel && direction_sel && hall_code == 3'h5
        |=> !upper_drive_a && lower_drive_c == $past(conduct) && !lower_drive_b)
        else $error("120 degree step 0 wrong");
    a_onetwenty_rev: assert property (@(posedge clk) disable iff (!rst_n)
        !phase_sel && !direction_sel && hall_code == 3'h3
        |=> !upper_drive_b && upper_drive_c && lower_drive_c == $past(conduct))
        else $error("240 degree order not served by reversed decode");
    a_twenty_rev: assert property (@(posedge clk) disable iff (!rst_n)
        !phase_sel && !direction_sel && hall_code == 3'h6
        |=> !upper_drive_a && lower_drive_b == $past(conduct) && step_valid)
        else $error("120 degree reversed step 2 wrong");

    // the other illegal code of each phasing also leaves the bridge off
    a_bad_invalid: assert property (@(posedge clk) disable iff (!rst_n)
        (phase_sel && hall_code == 3'h5) || (!phase_sel && hall_code == 3'h0)
        |=> !step_valid && upper_ff == hcd_pkg::UPPER_ALL_OFF
            && lower_ff == hcd_pkg::LOWER_ALL_OFF)
        else $error("illegal code not flagged invalid");

    // no bottom conduction outside the modulator's on-time
    a_pwm_gated: assert property (@(posedge clk) disable iff (!rst_n)
        !conduct |=> lower_ff == hcd_pkg::LOWER_ALL_OFF && !pwm_active_ff)
        else $error("bottom drive conducted outside the pwm pulse");
endmodule : hcd_top

// [hcd_hall_model.sv]
// hall sensor model: rotor position codes for the four phasings and quadrature
// assumes the bench steps it one sector at a time; raw_en forces any code
`timescale 1ns/100ps
module hcd_hall_model (
    input wire logic [2:0] step,
    input wire logic [1:0] conv,
    input wire logic four_step,
    input wire logic raw_en,
    input wire logic [2:0] raw_code,
    output logic hall_a,
    output logic hall_b,
    output logic hall_c
);
    // one code per 60 degree sector, step 0 in the low field
    wire [17:0] seq_row = (conv == 2'h0) ? 18'o013764 :
                          (conv == 2'h1) ? 18'o132645 :
                          (conv == 2'h2) ? 18'o231546 : 18'o310467;
    // two sensors 90 degrees apart; c follows b as the b/c tie on the board
    wire [1:0] quad = (step[1:0] == 2'h0) ? 2'h2 : (step[1:0] == 2'h1) ? 2'h3 :
                      (step[1:0] == 2'h2) ? 2'h1 : 2'h0;
    wire [2:0] code = raw_en ? raw_code :
                      four_step ? {quad, quad[0]} : seq_row[3*step +: 3];
    assign {hall_a, hall_b, hall_c} = code;
endmodule : hcd_hall_model

// [hall_commutation_decoder_tb_top.sv]
// testbench for the hall commutation decoder: code sweep, four-step, pwm gating
// assumes a short pwm period so several periods fit in a brief run
`timescale 1ns/100ps
module hall_commutation_decoder_tb_top;
    localparam int PER = 20;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic [2:0] step = 3'h0;
    logic four_step = 1'b0;
    logic raw_en = 1'b1;
    logic [2:0] raw_code = 3'h4;
    logic phase_sel = 1'b1;
    logic direction_sel = 1'b1;
    logic [12:0] duty_level = 13'h1F;
    logic over_current = 1'b0;
    logic hall_a, hall_b, hall_c, step_valid, pwm_active;
    wire [2:0] up, lo;
    int err_total = 0;
    int check_count = 0;
    int cyc = 0;
    int n, k;

    always #2.5 clk = ~clk;

    hcd_hall_model i_hcd_hall_model (.step(step), .conv(2'h0), .four_step(four_step),
        .raw_en(raw_en), .raw_code(raw_code), .hall_a(hall_a), .hall_b(hall_b),
        .hall_c(hall_c));

    hcd_top #(.PWM_PERIOD_CYC(PER)) i_hcd_top (.clk(clk), .rst_n(rst_n), .hall_in_a(hall_a),
        .hall_in_b(hall_b), .hall_in_c(hall_c), .phase_sel(phase_sel),
        .direction_sel(direction_sel), .duty_level(duty_level), .over_current(over_current),
        .upper_drive_a(up[0]), .upper_drive_b(up[1]), .upper_drive_c(up[2]),
        .lower_drive_a(lo[0]), .lower_drive_b(lo[1]), .lower_drive_c(lo[2]),
        .step_valid(step_valid), .pwm_active(pwm_active));

    task automatic end_sim();
        if (err_total == 0 && check_count > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask : end_sim

    task automatic check(input logic [6:0] got, input logic [6:0] exp, input string what);
        check_count++;
        if (got !== exp) begin
            err_total++;
            $display("ERROR %0t %s got %h exp %h", $time, what, got, exp);
        end
    endtask : check

    // expected {upper c..a, lower c..a, valid}; upper pins are low when on
    function automatic logic [6:0] expect_drv(input logic [2:0] code, input logic ps,
                                              input logic dir);
        logic [17:0] seq;
        logic [1:0] t, b;
        logic [6:0] r;
        r = {3'h7, 3'h0, 1'b0};
        seq = ps ? 18'o013764 : 18'o132645;
        for (int s = 0; s < 6; s++) begin
            if (seq[3*s +: 3] == code) begin
                t = 2'(12'o1224 >> (2*s));
                b = 2'(12'o2412 >> (2*s));
                if (!dir) begin
                    {t, b} = {b, t};
                end
                r = {~(3'h1 << t), 3'h1 << b, 1'b1};
            end
        end
        return r;
    endfunction : expect_drv

    // drives take effect on the edge that samples them, one edge after they are applied
    task automatic apply(input logic [2:0] code, input logic ps, input logic dir);
        @(posedge clk);
        raw_code <= code;
        phase_sel <= ps;
        direction_sel <= dir;
        @(posedge clk);
        @(negedge clk);
        check({up, lo, step_valid}, expect_drv(code, ps, dir), "drive");
    endtask : apply

    // hang guard, well above the roughly 140 cycles the tests need
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 4000) begin
            err_total++;
            end_sim();
        end
    end

    initial begin
        repeat (2) @(posedge clk);
        @(negedge clk);
        check({up, lo, pwm_active}, {3'h7, 3'h0, 1'b0}, "reset");
        @(posedge clk);
        rst_n <= 1'b1;
        repeat (2) @(posedge clk);
        for (int m = 0; m < 32; m++) begin
            apply(m[2:0], m[3], m[4]);
        end
        @(posedge clk);
        raw_en <= 1'b0;
        four_step <= 1'b1;
        for (int m = 0; m < 8; m++) begin
            @(posedge clk);
            step <= 3'(m[1:0]);
            direction_sel <= ~m[2];
            phase_sel <= 1'b1;
            @(posedge clk);
            @(negedge clk);
            n = m[2] ? (16'h4DE8 >> (4*m[1:0])) : (16'hE84D >> (4*m[1:0]));
            check({3'h0, up[1], up[2], lo[1], lo[2]}, {3'h0, 4'(n)}, "four");
        end
        // pwm gating with brush code, forward
        @(posedge clk);
        raw_en <= 1'b1;
        raw_code <= 3'h4;
        direction_sel <= 1'b1;
        duty_level <= 13'h5;
        repeat (PER) @(posedge clk);
        n = 0;
        repeat (PER) begin
            @(negedge clk);
            n += pwm_active + lo[2];
        end
        check(7'(n), 7'hA, "pwm width");
        k = 0;
        while (pwm_active !== 1'b1 && k < 3*PER) begin
            @(negedge clk);
            k++;
        end
        @(posedge clk);
        over_current <= 1'b1;
        @(posedge clk);
        over_current <= 1'b0;
        @(negedge clk);
        check({up, lo, pwm_active}, {3'h6, 3'h0, 1'b0}, "oc cut");
        n = 0;
        repeat (10) begin
            @(negedge clk);
            n += pwm_active + lo[2];
        end
        check(7'(n), 7'h0, "one pulse");
        end_sim();
    end
endmodule : hall_commutation_decoder_tb_top
